// [t0apm_pkg.sv]
/*
 * package for the card-side T=0 transport command interpreter: byte codes,
 * header layout, states and the structs that carry commands and answers.
 * assumes a byte-serial link layer outside that frames characters.
 */
package t0apm_pkg;

    // ************************************************************
    // procedure and status codes
    // ************************************************************
    localparam logic [7:0]  SW1_MORE_DATA = 8'h61;
    localparam logic [7:0]  SW1_WRONG_LEN = 8'h6C;
    localparam logic [15:0] SW_OK         = 16'h9000;
    localparam logic [15:0] SW_FAIL       = 16'h6F00;
    localparam logic [15:0] SW_NO_DATA    = 16'h6A82;
    localparam logic [7:0]  INS_GET_RESP  = 8'hC0;
    localparam logic [7:0]  P3_NONE       = 8'h00;

    // ************************************************************
    // header byte positions, in received order
    // ************************************************************
    localparam logic [2:0] HDR_CLA = 3'h0;
    localparam logic [2:0] HDR_INS = 3'h1;
    localparam logic [2:0] HDR_P1  = 3'h2;
    localparam logic [2:0] HDR_P2  = 3'h3;
    localparam logic [2:0] HDR_P3  = 3'h4;
    localparam logic [2:0] HDR_LEN = 3'h5;

    // ************************************************************
    // command cases as classified from the header, the body flag and the core's avail count
    // ************************************************************
    typedef enum logic [1:0] {
        T0APM_CASE1 = 2'b00,
        T0APM_CASE2 = 2'b01,
        T0APM_CASE3 = 2'b10
    } t0apm_case_t;

    typedef enum logic [2:0] {
        T0APM_HDR   = 3'b000,
        T0APM_EXEC  = 3'b001,
        T0APM_BODY  = 3'b010,
        T0APM_WAIT  = 3'b011,
        T0APM_DATA  = 3'b100,
        T0APM_SW1   = 3'b101,
        T0APM_SW2   = 3'b110
    } t0apm_state_t;

    typedef struct packed {
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
    } t0apm_hdr_t;

    // answer from the application core after processing
    typedef struct packed {
        logic        ok;
        logic [15:0] sw;
        logic [8:0]  avail;
    } t0apm_result_t;

endpackage : t0apm_pkg

// [t0apm_classify.sv]
/*
 * classifies a received header into command case and decides the answer
 * word pair for a case 2 length check.
 * assumes the header is stable while it is read and that the core tells
 * which instructions carry data in (case 3) and which return data (case 2).
 */
`timescale 1ns/1ps
module t0apm_classify
    import t0apm_pkg::*;
(
    input  wire t0apm_pkg::t0apm_hdr_t hdr,
    input  wire logic                  ins_has_body,
    input  wire logic [8:0]            avail,
    output t0apm_pkg::t0apm_case_t     cmd_case,
    output logic            len_bad,
    output logic [7:0]      len_fix
);
    always_comb begin
        // p3 = 00 means no body for case 1 and 256 data bytes for case 2
        if (ins_has_body) begin
            cmd_case = T0APM_CASE3;
        end else if (hdr.p3 == P3_NONE && avail == 9'h000) begin
            cmd_case = T0APM_CASE1;
        end else begin
            cmd_case = T0APM_CASE2;
        end
    end

    always_comb begin
        len_fix = avail[7:0];
        if (hdr.p3 == P3_NONE) begin
            len_bad = (avail != 9'h100) && (avail != 9'h000);
        end else begin
            len_bad = ({1'b0, hdr.p3} > avail);
        end
    end
endmodule : t0apm_classify

// [t0apm_card.sv]
/*
 * card-side T=0 transport mapper: takes header bytes, classifies the case,
 * receives body data, returns data, procedure pairs and status words.
 * assumes a character link layer that delivers rx bytes as one-cycle
 * strobes and accepts tx bytes when tx_ready is high; an application
 * core answers each command other than get response with a result strobe.
 */
//
// Behaviour
// - after 61xx or 6Cxx command continues
// - success is reported as status 9000
// - status describes the latest command only
// - case 1 header answered by status only
// - p3 together with the core's avail decides case 1 versus case 2
// - case 2 success returns data, uses 6Cxx/61xx
// - case 2 failure returns status words only
// - case 3 status only after full body
`timescale 1ns/1ps
module t0apm_card
    import t0apm_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 tx_ready,
    output logic                      tx_valid,
    output logic [7:0]                tx_byte,
    input  wire logic                 ins_has_body,
    output logic                      cmd_valid,
    output t0apm_pkg::t0apm_hdr_t     cmd_hdr,
    output logic                      body_valid,
    output logic [7:0]                body_byte,
    input  wire logic                 res_valid,
    input  wire t0apm_pkg::t0apm_result_t res,
    input  wire logic [7:0]           rsp_byte,
    output logic                      rsp_pop,
    output logic                      busy
);
    t0apm_state_t  state_reg;
    t0apm_hdr_t    hdr_reg;
    t0apm_result_t res_reg;
    logic [2:0]    idx_reg;
    logic [8:0]    cnt_reg;
    logic [8:0]    pend_reg;
    logic [15:0]   sw_reg;
    t0apm_case_t   cmd_case;
    logic          len_bad;
    logic [7:0]    len_fix;
    logic          tx_take;

    t0apm_classify u_classify (
        .hdr          (hdr_reg),
        .ins_has_body (ins_has_body),
        .avail        (res_reg.avail),
        .cmd_case     (cmd_case),
        .len_bad      (len_bad),
        .len_fix      (len_fix)
    );

    assign tx_take = tx_valid && tx_ready;

    // ************************************************************
    // header towards the core
    // ************************************************************
    // p3 lands on the edge that raises cmd_valid, so the core sees
    // the whole header together with the strobe
    assign cmd_hdr = hdr_reg;

    function automatic logic [8:0] want_len(input logic [7:0] p3);
        want_len = (p3 == P3_NONE) ? 9'h100 : {1'b0, p3};
    endfunction : want_len

    // ************************************************************
    // command sequencer
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg  <= T0APM_HDR;
            hdr_reg    <= '0;
            res_reg    <= '0;
            idx_reg    <= 3'h0;
            cnt_reg    <= 9'h000;
            pend_reg   <= 9'h000;
            sw_reg     <= 16'h0000;
            cmd_valid  <= 1'b0;
            body_valid <= 1'b0;
            body_byte  <= 8'h00;
            tx_valid   <= 1'b0;
            tx_byte    <= 8'h00;
            rsp_pop    <= 1'b0;
            busy       <= 1'b0;
        end else begin
            cmd_valid  <= 1'b0;
            body_valid <= 1'b0;
            rsp_pop    <= 1'b0;
            unique case (state_reg)
                T0APM_HDR: begin
                    busy <= 1'b0;
                    if (rx_valid) begin
                        unique case (idx_reg)
                            HDR_CLA: hdr_reg.cla <= rx_byte;
                            HDR_INS: hdr_reg.ins <= rx_byte;
                            HDR_P1:  hdr_reg.p1  <= rx_byte;
                            HDR_P2:  hdr_reg.p2  <= rx_byte;
                            default: hdr_reg.p3  <= rx_byte;
                        endcase
                        if (idx_reg == HDR_P3) begin
                            idx_reg <= 3'h0;
                            busy    <= 1'b1;
                            if (ins_has_body) begin
                                // ack with ins byte, then take body
                                tx_valid <= 1'b1;
                                tx_byte  <= hdr_reg.ins;
                                cnt_reg  <= 9'h000;
                                state_reg <= T0APM_BODY;
                            end else if (hdr_reg.ins == INS_GET_RESP && pend_reg == 9'h000) begin
                                sw_reg    <= SW_NO_DATA;
                                state_reg <= T0APM_SW1;
                            end else if (hdr_reg.ins == INS_GET_RESP) begin
                                // get response is a fresh case 2 command
                                res_reg   <= '{ok: 1'b1, sw: SW_OK, avail: pend_reg};
                                state_reg <= T0APM_WAIT;
                            end else begin
                                cmd_valid <= 1'b1;
                                state_reg <= T0APM_EXEC;
                            end
                        end else begin
                            idx_reg <= idx_reg + 3'h1;
                        end
                    end
                end
                T0APM_BODY: begin
                    if (tx_take) begin
                        tx_valid <= 1'b0;
                    end
                    if (rx_valid) begin
                        body_valid <= 1'b1;
                        body_byte  <= rx_byte;
                        cnt_reg    <= cnt_reg + 9'h001;
                        if (cnt_reg + 9'h001 == want_len(hdr_reg.p3)) begin
                            cmd_valid <= 1'b1;
                            state_reg <= T0APM_EXEC;
                        end
                    end
                end
                T0APM_EXEC: begin
                    if (tx_take) begin
                        tx_valid <= 1'b0;
                    end
                    if (res_valid) begin
                        res_reg   <= res;
                        pend_reg  <= 9'h000;
                        state_reg <= T0APM_WAIT;
                    end
                end
                T0APM_WAIT: begin
                    cnt_reg <= 9'h000;
                    if (!res_reg.ok || cmd_case != T0APM_CASE2) begin
                        // failure or case 1/3: status only
                        sw_reg    <= res_reg.ok ? SW_OK : res_reg.sw;
                        state_reg <= T0APM_SW1;
                    end else if (len_bad) begin
                        // wrong length: keep data pending, ask for resend
                        sw_reg    <= {SW1_WRONG_LEN, len_fix};
                        pend_reg  <= res_reg.avail;
                        state_reg <= T0APM_SW1;
                    end else begin
                        tx_valid  <= 1'b1;
                        tx_byte   <= hdr_reg.ins;
                        pend_reg  <= res_reg.avail;
                        state_reg <= T0APM_DATA;
                    end
                end
                T0APM_DATA: begin
                    if (tx_take) begin
                        if (cnt_reg == want_len(hdr_reg.p3)) begin
                            tx_valid <= 1'b0;
                            pend_reg <= pend_reg - want_len(hdr_reg.p3);
                            if (pend_reg > want_len(hdr_reg.p3)) begin
                                // remainder left: direct a get response
                                sw_reg <= {SW1_MORE_DATA,
                                    8'(pend_reg - want_len(hdr_reg.p3))};
                            end else begin
                                sw_reg <= SW_OK;
                            end
                            state_reg <= T0APM_SW1;
                        end else begin
                            tx_byte <= rsp_byte;
                            rsp_pop <= 1'b1;
                            cnt_reg <= cnt_reg + 9'h001;
                        end
                    end
                end
                T0APM_SW1: begin
                    tx_valid <= 1'b1;
                    tx_byte  <= sw_reg[15:8];
                    if (tx_take && tx_byte == sw_reg[15:8]) begin
                        tx_byte   <= sw_reg[7:0];
                        state_reg <= T0APM_SW2;
                    end
                end
                T0APM_SW2: begin
                    if (tx_take) begin
                        tx_valid  <= 1'b0;
                        state_reg <= T0APM_HDR;
                    end
                end
                default: state_reg <= T0APM_HDR;
            endcase
        end
    end
endmodule : t0apm_card

// [t0apm_card_props.sv]
/* port assertions for the card-side mapper; bound to t0apm_card */
`timescale 1ns/1ps
module t0apm_card_props
    import t0apm_pkg::*;
(
    input wire logic                     clk_sys,
    input wire logic                     nrst,
    input wire logic                     rx_valid,
    input wire logic [7:0]               rx_byte,
    input wire logic                     tx_ready,
    input wire logic                     tx_valid,
    input wire logic [7:0]               tx_byte,
    input wire logic                     ins_has_body,
    input wire logic                     cmd_valid,
    input wire t0apm_pkg::t0apm_hdr_t    cmd_hdr,
    input wire logic                     body_valid,
    input wire logic [7:0]               body_byte,
    input wire logic                     res_valid,
    input wire t0apm_pkg::t0apm_result_t res,
    input wire logic [7:0]               rsp_byte,
    input wire logic                     rsp_pop,
    input wire logic                     busy
);
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_offer; tx_valid && !tx_ready; endsequence
    sequence s_proc_taken; tx_valid && tx_ready && tx_byte == SW1_WRONG_LEN; endsequence
    AST_TX_HOLD: assert property (s_offer |=> tx_valid && $stable(tx_byte))
        else $error("tx byte changed before taken");
    AST_SW_AFTER_RES: assert property (res_valid |-> ##3 tx_valid)
        else $error("no answer three cycles after result");
    AST_CMD_BUSY: assert property (cmd_valid |-> busy ##1 busy)
        else $error("idle while command processed");
    AST_IDLE_QUIET: assert property (!busy |-> !tx_valid)
        else $error("tx while idle");
    AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe too long");
    AST_BODY_COPY: assert property (body_valid |-> $past(rx_valid) && body_byte == $past(rx_byte))
        else $error("body byte not the received byte");
    AST_RESET_QUIET: assert property ($rose(nrst) |-> !tx_valid && !busy && !cmd_valid)
        else $error("outputs active after reset");
    AST_PROC_BUSY: assert property (s_proc_taken |=> busy)
        else $error("procedure byte ended command");
endmodule : t0apm_card_props

bind t0apm_card t0apm_card_props u_props (.clk_sys(clk_sys), .nrst(nrst), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .ins_has_body(ins_has_body), .cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr),
    .body_valid(body_valid), .body_byte(body_byte), .res_valid(res_valid), .res(res),
    .rsp_byte(rsp_byte), .rsp_pop(rsp_pop), .busy(busy));

// [t0apm_term_model.sv]
/* terminal model: sends headers and body, takes tx bytes with random stalls */
`timescale 1ns/1ps
module t0apm_term_model
    import t0apm_pkg::*;
(
    input  wire logic       clk_sys,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready
);
    // ************************************************************
    // link
    // ************************************************************
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'hFF;
        tx_ready = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) got.push_back(tx_byte);
        tx_ready <= #1 ($urandom_range(0, 3) != 0);
    end
    task automatic put(input logic [7:0] b);
        @(posedge clk_sys);
        #1 rx_valid = 1'b1;
        rx_byte = b;
        @(posedge clk_sys);
        #1 rx_valid = 1'b0;
        rx_byte = ~b; // line shows no stale value
    endtask : put
    task automatic send_cmd(input t0apm_hdr_t h, input int n);
        int k;
        put(h.cla);
        put(h.ins);
        put(h.p1);
        put(h.p2);
        put(h.p3);
        for (k = 0; k < 500 && n > 0 && got.size() == 0; k++) @(posedge clk_sys);
        for (k = 0; k < n && got.size() > 0 && got[0] == h.ins; k++) put(8'h30 + k[7:0]);
    endtask : send_cmd
endmodule : t0apm_term_model

// [t0apm_card_tb_top.sv]
/* self-checking bench for t0apm_card; core answers each command except get response */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module t0apm_card_tb_top;
    import t0apm_pkg::*;
    // ************************************************************
    // setup
    // ************************************************************
    logic          clk_sys, nrst, rx_valid, tx_ready, tx_valid, ins_has_body;
    logic          cmd_valid, body_valid, res_valid, rsp_pop, busy;
    logic [7:0]    rx_byte, tx_byte, body_byte, rsp_byte;
    t0apm_result_t res, cur_res;
    t0apm_hdr_t    h, cmd_hdr;
    int            err_total, n_tests, body_n, len;
    logic [8:0]    av;
    logic [7:0]    exp_q[$];
    logic [7:0]    d_base;
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    t0apm_card dut (.clk_sys(clk_sys), .nrst(nrst), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .ins_has_body(ins_has_body),
        .cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr), .body_valid(body_valid), .body_byte(body_byte),
        .res_valid(res_valid), .res(res), .rsp_byte(rsp_byte), .rsp_pop(rsp_pop), .busy(busy));
    t0apm_term_model term (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
    // core shows the next byte as soon as the card pops the current one
    always @(posedge clk_sys) #1 if (rsp_pop) rsp_byte = rsp_byte + 8'h01;
    always @(posedge clk_sys) if (body_valid) begin
        `CHK(body_byte, 8'h30 + body_n[7:0])
        body_n++;
    end
    always @(posedge clk_sys) if (cmd_valid) begin
        `CHK(cmd_hdr, h)
        repeat ($urandom_range(1, 4)) @(posedge clk_sys);
        #1 res_valid = 1'b1;
        res = cur_res;
        @(posedge clk_sys);
        #1 res_valid = 1'b0;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    function automatic void build_exp(t0apm_hdr_t c, logic b, logic ok, logic [15:0] sw,
                                      logic [8:0] a);
        logic [8:0] le;
        le = (c.p3 == P3_NONE) ? 9'h100 : {1'b0, c.p3};
        if (ok) sw = SW_OK;
        exp_q = {};
        if (b) exp_q.push_back(c.ins);
        if (!b && ok && !(c.p3 == P3_NONE && a == 9'h000)) begin
            if (le > a) begin
                exp_q = {SW1_WRONG_LEN, a[7:0]};
                return;
            end
            exp_q.push_back(c.ins);
            for (int i = 0; i < le; i++) exp_q.push_back(d_base + i[7:0]);
            d_base += le[7:0];
            if (a > le) begin
                exp_q.push_back(SW1_MORE_DATA);
                exp_q.push_back(8'(a - le));
                return;
            end
        end
        exp_q.push_back(sw[15:8]);
        exp_q.push_back(sw[7:0]);
    endfunction : build_exp
    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic run_cmd(t0apm_hdr_t c, logic b, logic ok, logic [15:0] sw, logic [8:0] a);
        int k;
        @(posedge clk_sys);
        #1 ins_has_body = b;
        rsp_byte = d_base;
        build_exp(c, b, ok, sw, a);
        cur_res = '{ok: ok, sw: sw, avail: a};
        body_n = 0;
        term.got = {};
        term.send_cmd(c, b ? int'(c.p3) : 0);
        for (k = 0; k < 9000 && (term.got.size() < exp_q.size() || busy); k++) @(posedge clk_sys);
        if (k == 9000) begin
            err_total++;
            $display("BAD %0t command never finished", $time);
            stop_test();
        end
        `CHK(term.got.size(), exp_q.size())
        if (term.got.size() == exp_q.size())
            foreach (exp_q[i]) `CHK(term.got[i], exp_q[i])
        `CHK(body_n, b ? int'(c.p3) : 0)
        $display("command %h done, %0d bytes back", c.ins, exp_q.size());
    endtask : run_cmd
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        void'($urandom(86897));
        {nrst, ins_has_body, res_valid} = 3'h0;
        res = '0;
        cur_res = '0;
        d_base = 8'hA0;
        rsp_byte = 8'hA0;
        {err_total, n_tests, body_n} = 0;
        repeat (3) @(posedge clk_sys);
        #1 nrst = 1'b1;
        h = '{8'h00, 8'h44, 8'h00, 8'h00, P3_NONE};
        run_cmd(h, 1'b0, 1'b1, SW_OK, 9'h000);
        run_cmd(h, 1'b0, 1'b0, SW_FAIL, 9'h000);
        run_cmd(h, 1'b0, 1'b1, SW_OK, 9'h100);
        run_cmd(h, 1'b0, 1'b1, SW_OK, 9'h020);
        h.p3 = 8'h01;
        run_cmd(h, 1'b1, 1'b1, SW_OK, 9'h000);
        h.p3 = 8'hFF;
        run_cmd(h, 1'b1, 1'b1, SW_OK, 9'h000);
        run_cmd(h, 1'b0, 1'b1, SW_OK, 9'h0FF);
        // warning after body data: terminal goes on with a get response
        h.p3 = 8'h04;
        run_cmd(h, 1'b1, 1'b0, 16'h6283, 9'h000);
        h.ins = INS_GET_RESP;
        h.p3 = P3_NONE;
        run_cmd(h, 1'b0, 1'b0, SW_NO_DATA, 9'h000);
        for (int n = 0; n < 16; n++) begin
            h = {$urandom, 8'($urandom)};
            if (h.ins == INS_GET_RESP) h.ins = 8'hB0;
            len = $urandom_range(2, 255);
            h.p3 = len[7:0];
            av = 9'($urandom_range(1, len - 1));
            case (n % 4)
                0: run_cmd(h, 1'b1, 1'b1, SW_OK, 9'h000);
                1: begin
                    run_cmd(h, 1'b0, 1'b1, SW_OK, av);
                    h.p3 = av[7:0];
                    run_cmd(h, 1'b0, 1'b1, SW_OK, av);
                end
                2: begin
                    av = 9'($urandom_range(len + 1, 256));
                    run_cmd(h, 1'b0, 1'b1, SW_OK, av);
                    h.ins = INS_GET_RESP;
                    h.p3 = 8'(av - len);
                    run_cmd(h, 1'b0, 1'b1, SW_OK, 9'(av - len));
                end
                default: run_cmd(h, 1'b0, 1'b0, SW_NO_DATA, av);
            endcase
        end
        stop_test();
    end
endmodule : t0apm_card_tb_top
